// ===== rtl/hpdc_top.sv
// Host port DMA request and irq configuration with AHB-Lite registers
//
// The AHB-Lite slave port was left to the implementer.
`timescale 1ns/10ps

module hpdc_top (
  input  wire logic        ref_clk,
  input  wire logic        reset,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  // Internal sources
  input  wire logic        dma_ready,
  input  wire logic        event_irq,
  input  wire logic        word_xfer,
  input  wire logic        xfer_last,
  // Host pins
  input  wire logic        dma_ack_line,
  output logic             dma_request_line,
  output logic             host_irq_line
);

  // Decode a word address into a register selection
  function automatic hpdc_pkg::hpdc_sel_t decode_sel(
    input logic [31:0] addr
  );
    logic [31:0] word;
    word = {addr[31:2], 2'b00};
    if (word == hpdc_pkg::ADDR_HOST_PORT_CONFIG) begin
      decode_sel = hpdc_pkg::HPDC_SEL_CFG;
    end else if (word == hpdc_pkg::ADDR_INTERNAL_IFACE_CONFIG) begin
      decode_sel = hpdc_pkg::HPDC_SEL_COPY;
    end else if (word == hpdc_pkg::ADDR_STATUS) begin
      decode_sel = hpdc_pkg::HPDC_SEL_STAT;
    end else begin
      decode_sel = hpdc_pkg::HPDC_SEL_NONE;
    end
  endfunction

  // Burst length in words, two to the power of the code
  function automatic logic [hpdc_pkg::WORD_CNT_W-1:0] burst_words(
    input logic [3:0] code
  );
    burst_words = hpdc_pkg::WORD_CNT_W'(1) << code;
  endfunction

  // Configuration fields
  logic        ack_polarity;
  logic        req_polarity;
  logic        req_force_value;
  logic        req_force_enable;
  logic        irq_polarity;
  logic        irq_force_value;
  logic        irq_force_enable;
  logic        req_signalling_mode;
  logic        init_mode_flag;
  logic [3:0]  burst_length_code;

  // Bus pipeline
  logic                  bus_wr_pend;
  logic                  bus_rd_pend;
  hpdc_pkg::hpdc_sel_t   bus_sel;
  logic                  take_addr;

  // Acknowledge pin synchroniser
  logic        ack_meta;
  logic        ack_s2;
  logic        ack_s3;
  logic        ack_level;
  logic        ack_active;

  // Request sequencer
  hpdc_pkg::hpdc_state_t                 state;
  hpdc_pkg::hpdc_state_t                 next_state;
  logic [hpdc_pkg::WORD_CNT_W-1:0]       word_cnt;
  logic [hpdc_pkg::GAP_CNT_W-1:0]        gap_cnt;
  logic                                  burst_done;
  logic                                  fsm_req;
  logic                                  req_active;
  logic                                  irq_active;
  logic                                  ack_seen;
  logic                                  ack_dropped;

  // Register read views
  logic [31:0] cfg_word;
  logic [31:0] copy_word;
  logic [31:0] stat_word;

  // Address phase is taken on a valid transfer while the bus is ready
  assign take_addr = hsel && hready && htrans[1];

  // Read data: one wait state, write: none
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      bus_wr_pend <= 1'b0;
      bus_rd_pend <= 1'b0;
      bus_sel     <= hpdc_pkg::HPDC_SEL_NONE;
    end else if (take_addr) begin
      bus_wr_pend <= hwrite;
      bus_rd_pend <= !hwrite;
      bus_sel     <= decode_sel(haddr);
    end else if (hreadyout) begin
      bus_wr_pend <= 1'b0;
      bus_rd_pend <= 1'b0;
    end
  end

  // Ready and response; response is always OKAY
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      hreadyout <= !(take_addr && !hwrite);
      hresp     <= 1'b0;
    end
  end

  // Read data captured in the wait state; unmapped reads give zero
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      hrdata <= 32'h0000_0000;
    end else if (bus_rd_pend && !hreadyout) begin
      unique case (bus_sel)
        hpdc_pkg::HPDC_SEL_CFG:  hrdata <= cfg_word;
        hpdc_pkg::HPDC_SEL_COPY: hrdata <= copy_word;
        hpdc_pkg::HPDC_SEL_STAT: hrdata <= stat_word;
        hpdc_pkg::HPDC_SEL_NONE: hrdata <= 32'h0000_0000;
      endcase
    end
  end

  // Configuration register, written in the data phase
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      ack_polarity <=
        hpdc_pkg::CONFIG_RESET[hpdc_pkg::ACK_POLARITY_BIT];
      req_polarity <=
        hpdc_pkg::CONFIG_RESET[hpdc_pkg::REQ_POLARITY_BIT];
      req_force_value <=
        hpdc_pkg::CONFIG_RESET[hpdc_pkg::REQ_FORCE_VALUE_BIT];
      req_force_enable <=
        hpdc_pkg::CONFIG_RESET[hpdc_pkg::REQ_FORCE_ENABLE_BIT];
      irq_polarity <=
        hpdc_pkg::CONFIG_RESET[hpdc_pkg::IRQ_POLARITY_BIT];
      irq_force_value <=
        hpdc_pkg::CONFIG_RESET[hpdc_pkg::IRQ_FORCE_VALUE_BIT];
      irq_force_enable <=
        hpdc_pkg::CONFIG_RESET[hpdc_pkg::IRQ_FORCE_ENABLE_BIT];
      req_signalling_mode <=
        hpdc_pkg::CONFIG_RESET[hpdc_pkg::REQ_MODE_BIT];
      burst_length_code <= hpdc_pkg::CONFIG_RESET[
        hpdc_pkg::BURST_CODE_LSB +: hpdc_pkg::BURST_CODE_W];
    end else if (bus_wr_pend && bus_sel == hpdc_pkg::HPDC_SEL_CFG) begin
      ack_polarity        <= hwdata[hpdc_pkg::ACK_POLARITY_BIT];
      req_polarity        <= hwdata[hpdc_pkg::REQ_POLARITY_BIT];
      req_force_value     <= hwdata[hpdc_pkg::REQ_FORCE_VALUE_BIT];
      req_force_enable    <= hwdata[hpdc_pkg::REQ_FORCE_ENABLE_BIT];
      irq_polarity        <= hwdata[hpdc_pkg::IRQ_POLARITY_BIT];
      irq_force_value     <= hwdata[hpdc_pkg::IRQ_FORCE_VALUE_BIT];
      irq_force_enable    <= hwdata[hpdc_pkg::IRQ_FORCE_ENABLE_BIT];
      req_signalling_mode <= hwdata[hpdc_pkg::REQ_MODE_BIT];
      burst_length_code   <= hwdata[
        hpdc_pkg::BURST_CODE_LSB +: hpdc_pkg::BURST_CODE_W];
    end
  end

  // Single init mode flop, written through either register view
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      init_mode_flag <=
        hpdc_pkg::CONFIG_RESET[hpdc_pkg::INIT_MODE_BIT];
    end else if (bus_wr_pend && bus_sel == hpdc_pkg::HPDC_SEL_COPY) begin
      init_mode_flag <= hwdata[hpdc_pkg::INIT_COPY_BIT];
    end else if (bus_wr_pend && bus_sel == hpdc_pkg::HPDC_SEL_CFG) begin
      init_mode_flag <= hwdata[hpdc_pkg::INIT_MODE_BIT];
    end
  end

  // Register read views
  always_comb begin
    cfg_word = 32'h0000_0000;
    cfg_word[hpdc_pkg::ACK_POLARITY_BIT]     = ack_polarity;
    cfg_word[hpdc_pkg::REQ_POLARITY_BIT]     = req_polarity;
    cfg_word[hpdc_pkg::REQ_FORCE_VALUE_BIT]  = req_force_value;
    cfg_word[hpdc_pkg::REQ_FORCE_ENABLE_BIT] = req_force_enable;
    cfg_word[hpdc_pkg::IRQ_POLARITY_BIT]     = irq_polarity;
    cfg_word[hpdc_pkg::IRQ_FORCE_VALUE_BIT]  = irq_force_value;
    cfg_word[hpdc_pkg::IRQ_FORCE_ENABLE_BIT] = irq_force_enable;
    cfg_word[hpdc_pkg::REQ_MODE_BIT]         = req_signalling_mode;
    cfg_word[hpdc_pkg::INIT_MODE_BIT]        = init_mode_flag;
    cfg_word[hpdc_pkg::BURST_CODE_LSB +: hpdc_pkg::BURST_CODE_W] =
      burst_length_code;
  end

  // Internal copy shows the same flop
  always_comb begin
    copy_word = 32'h0000_0000;
    copy_word[hpdc_pkg::INIT_COPY_BIT] = init_mode_flag;
  end

  // Status view of the sequencer
  always_comb begin
    stat_word = 32'h0000_0000;
    stat_word[hpdc_pkg::STAT_STATE_LSB +: 2] = state;
    stat_word[hpdc_pkg::STAT_ACK_BIT]        = ack_active;
    stat_word[hpdc_pkg::STAT_REQ_BIT]        = req_active;
    stat_word[hpdc_pkg::STAT_IRQ_BIT]        = irq_active;
    stat_word[hpdc_pkg::STAT_CNT_LSB +: hpdc_pkg::WORD_CNT_W] = word_cnt;
  end

  // Three-stage pin synchroniser, reset to the idle level of an active-low
  // acknowledge so that no false acknowledge follows reset
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      ack_meta <= 1'b1;
      ack_s2   <= 1'b1;
      ack_s3   <= 1'b1;
    end else begin
      ack_meta <= dma_ack_line;
      ack_s2   <= ack_meta;
      ack_s3   <= ack_s2;
    end
  end

  // Accept a pin change only when stages two and three agree
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      ack_level <= 1'b1;
    end else if (ack_s2 == ack_s3) begin
      ack_level <= ack_s3;
    end
  end

  // Acknowledge polarity
  assign ack_active = ack_polarity ? ack_level : !ack_level;

  // Burst end: bounded count or last transfer cycle when unbounded
  always_comb begin
    if (burst_length_code == hpdc_pkg::BURST_UNBOUNDED) begin
      burst_done = ack_active && word_xfer && xfer_last;
    end else begin
      burst_done = ack_active && word_xfer &&
        (word_cnt + hpdc_pkg::WORD_CNT_W'(1) ==
         burst_words(burst_length_code));
    end
  end

  // Request sequencer next state
  always_comb begin
    next_state = state;
    unique case (state)
      hpdc_pkg::HPDC_IDLE: begin
        if (dma_ready) begin
          next_state = hpdc_pkg::HPDC_REQ;
        end
      end
      hpdc_pkg::HPDC_REQ: begin
        if (req_signalling_mode) begin
          if (burst_done) begin
            next_state = hpdc_pkg::HPDC_HOLD;
          end
        end else if (ack_dropped) begin
          next_state = hpdc_pkg::HPDC_GAP;
        end
      end
      hpdc_pkg::HPDC_HOLD: begin
        if (!ack_active) begin
          next_state = hpdc_pkg::HPDC_IDLE;
        end
      end
      hpdc_pkg::HPDC_GAP: begin
        if (gap_cnt == hpdc_pkg::GAP_CNT_W'(1)) begin
          next_state = hpdc_pkg::HPDC_IDLE;
        end
      end
    endcase
  end

  // Pulse mode ends once an acknowledge was seen and has dropped
  assign ack_dropped = ack_seen && !ack_active;

  // Track whether acknowledge was active during this request
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      ack_seen <= 1'b0;
    end else if (state != hpdc_pkg::HPDC_REQ) begin
      ack_seen <= 1'b0;
    end else if (ack_active) begin
      ack_seen <= 1'b1;
    end
  end

  // State register
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      state <= hpdc_pkg::HPDC_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // Words moved in the current burst
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      word_cnt <= '0;
    end else if (state != hpdc_pkg::HPDC_REQ) begin
      word_cnt <= '0;
    end else if (ack_active && word_xfer) begin
      word_cnt <= word_cnt + hpdc_pkg::WORD_CNT_W'(1);
    end
  end

  // Gap timer, loaded on entry to the gap state
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      gap_cnt <= '0;
    end else if (next_state == hpdc_pkg::HPDC_GAP &&
                 state != hpdc_pkg::HPDC_GAP) begin
      gap_cnt <= hpdc_pkg::GAP_CNT_W'(hpdc_pkg::PULSE_GAP_CYCLES);
    end else if (gap_cnt != '0) begin
      gap_cnt <= gap_cnt - hpdc_pkg::GAP_CNT_W'(1);
    end
  end

  // Request is raised only in the request state
  assign fsm_req = (state == hpdc_pkg::HPDC_REQ);

  // Overrides take precedence over internal sources
  assign req_active = req_force_enable ? req_force_value : fsm_req;
  assign irq_active = irq_force_enable ? irq_force_value
                                       : event_irq;

  // Pin levels with polarity, straight from flops
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      dma_request_line <= 1'b1;
      host_irq_line    <= 1'b1;
    end else begin
      dma_request_line <= req_polarity ? req_active : !req_active;
      host_irq_line    <= irq_polarity ? irq_active : !irq_active;
    end
  end

endmodule

// ===== rtl/hpdc_pkg.sv
// Constants, field layout and types for the host port request/irq config
// How it works
// - The incoming acknowledge pin counts as active low when ack_polarity is 0 and active high when it is 1.
// - The request pin is driven active low when req_polarity is 0 and active high when it is 1.
// - With req_force_enable set the request pin is forced to req_force_value, otherwise nothing is forced.
// - With irq_force_enable set the irq pin is forced to irq_force_value, otherwise nothing is forced.
// - The irq polarity bit is applied directly by hardware to the irq pin level.
// - In pulse mode the request drops when the acknowledge drops and stays low for a fixed gap before it may rise again.
// - In burst mode the request drops after the burst of words and rises again only after the acknowledge has dropped.
// - A burst length code of 0 to 14 means two to that power words and matters only in burst mode.
// - A burst length code of 15 means an unbounded burst that ends only on the last cycle of the transfer.
// - The init mode flag reads 1 in initialization and 0 in normal operation, and firmware clears it through the internal copy.
// - The init mode flag is one bit shown identically in the host port config and the internal interface config.
package hpdc_pkg;

  // Register byte addresses
  localparam logic [31:0] ADDR_HOST_PORT_CONFIG      = 32'h0e0017e0;
  localparam logic [31:0] ADDR_INTERNAL_IFACE_CONFIG = 32'h0e0017f0;
  localparam logic [31:0] ADDR_STATUS                = 32'h0e0017f4;

  // host_port_config field positions
  localparam int ACK_POLARITY_BIT     = 15;
  localparam int REQ_POLARITY_BIT     = 14;
  localparam int REQ_FORCE_VALUE_BIT  = 13;
  localparam int REQ_FORCE_ENABLE_BIT = 12;
  localparam int IRQ_POLARITY_BIT     = 11;
  localparam int IRQ_FORCE_VALUE_BIT  = 10;
  localparam int IRQ_FORCE_ENABLE_BIT = 9;
  localparam int REQ_MODE_BIT         = 7;
  localparam int INIT_MODE_BIT        = 6;
  localparam int BURST_CODE_LSB       = 0;
  localparam int BURST_CODE_W         = 4;

  // Reset value of host_port_config and its writable bits other than init mode bit 6
  localparam logic [15:0] CONFIG_RESET = 16'h0045;
  localparam logic [15:0] CONFIG_WMASK = 16'hfe8f;

  // internal_iface_config: init mode copy position
  localparam int INIT_COPY_BIT = 0;

  // status register field positions
  localparam int STAT_STATE_LSB = 0;
  localparam int STAT_ACK_BIT   = 2;
  localparam int STAT_REQ_BIT   = 3;
  localparam int STAT_IRQ_BIT   = 4;
  localparam int STAT_CNT_LSB   = 16;

  // Burst encoding
  localparam logic [3:0] BURST_UNBOUNDED = 4'hf;
  localparam int         WORD_CNT_W      = 15;

  // Pulse mode gap time and its cycle count, rounded up
  localparam int CLK_PERIOD_NS    = 10;
  localparam int PULSE_GAP_NS     = 100;
  localparam int PULSE_GAP_CYCLES =
    (PULSE_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS < 1 ? 1 :
    (PULSE_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int GAP_CNT_W = 8;

  // AHB transfer type encodings
  localparam logic [1:0] HTRANS_NONSEQ = 2'b10;
  localparam logic [1:0] HTRANS_SEQ    = 2'b11;

  // Request sequencer states, Gray along idle-req-hold-gap
  typedef enum logic [1:0] {
    HPDC_IDLE = 2'b00,
    HPDC_REQ  = 2'b01,
    HPDC_HOLD = 2'b11,
    HPDC_GAP  = 2'b10
  } hpdc_state_t;

  // Register selection
  typedef enum logic [1:0] {
    HPDC_SEL_NONE = 2'b00,
    HPDC_SEL_CFG  = 2'b01,
    HPDC_SEL_COPY = 2'b10,
    HPDC_SEL_STAT = 2'b11
  } hpdc_sel_t;

endpackage

// ===== testbench/hpdc_checker.sv
// Assertions on the request and irq pins of the host port block
`timescale 1ns/10ps

module hpdc_checker (
  input wire logic        ref_clk,
  input wire logic        reset,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic        event_irq,
  input wire logic        word_xfer,
  input wire logic        xfer_last,
  input wire logic        dma_ack_line,
  input wire logic        dma_request_line,
  input wire logic        host_irq_line
);
  logic [15:0] c;
  logic [15:0] cq;
  logic [15:0] wc;
  logic        wr_cfg;
  wire         req_act = dma_request_line == cq[14];
  wire         ack_act = dma_ack_line == c[15];
  wire         pmode   = !cq[7] && !cq[12];
  wire         bmode   = cq[7] && !cq[12];

  default clocking @(posedge ref_clk);
  endclocking
  default disable iff (reset);

  // Shadow of the config register, fed from completed bus writes
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      wr_cfg <= 1'b0;
      c      <= hpdc_pkg::CONFIG_RESET;
    end else begin
      if (hready)
        wr_cfg <= hsel && htrans[1] && hwrite &&
                  haddr == hpdc_pkg::ADDR_HOST_PORT_CONFIG;
      if (wr_cfg && hready)
        c <= hwdata[15:0];
    end
  end

  // Config as the pin flops see it; words moved under one acknowledge
  always_ff @(posedge ref_clk) begin
    cq <= c;
    if (reset || !ack_act)
      wc <= 16'h0;
    else if (word_xfer)
      wc <= wc + 16'h1;
  end

  // Request stays away for eight cycles of the gap
  sequence s_quiet;
    !req_act [*8];
  endsequence

  chk_irq_forced: assert property (
    cq[9] |-> host_irq_line == ~(cq[11] ^ cq[10]))
    else $error("irq pin not at forced level");
  chk_irq_follow: assert property (
    !$past(reset) && !cq[9] |->
    host_irq_line == ~(cq[11] ^ $past(event_irq)))
    else $error("irq pin not following event");
  chk_req_forced: assert property (
    cq[12] |-> dma_request_line == ~(cq[14] ^ cq[13]))
    else $error("request pin not at forced level");
  chk_pulse_gap: assert property (
    pmode && $fell(req_act) |-> s_quiet)
    else $error("request back too soon");
  chk_pulse_hold: assert property (
    pmode && req_act && ack_act |=> req_act)
    else $error("request dropped while acknowledged");
  chk_burst_end: assert property (
    bmode && cq[3:0] != 4'hf && word_xfer &&
    (wc + 16'h1) == (16'h1 << cq[3:0]) |-> ##[1:3] !req_act)
    else $error("request stayed after full burst");
  chk_burst_rearm: assert property (
    bmode && ack_act && !req_act |=> !req_act)
    else $error("request back while acknowledged");
  chk_burst_open: assert property (
    bmode && cq[3:0] == 4'hf && word_xfer && xfer_last |->
    ##[1:3] !req_act)
    else $error("request stayed after last word");
endmodule

bind hpdc_top hpdc_checker u_chk (
  .ref_clk(ref_clk), .reset(reset), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready),
  .event_irq(event_irq), .word_xfer(word_xfer), .xfer_last(xfer_last),
  .dma_ack_line(dma_ack_line), .dma_request_line(dma_request_line),
  .host_irq_line(host_irq_line));

// ===== testbench/hpdc_host_model.sv
// Host side model that answers the request pin with an acknowledge
`timescale 1ns/10ps

module hpdc_host_model (
  input wire logic       ref_clk,
  input wire logic       reset,
  input wire logic       dma_request_line,
  input wire logic       req_pol,
  input wire logic       ack_pol,
  input wire logic [7:0] lat,
  input wire logic [7:0] hold,
  output logic           dma_ack_line
);
  logic ack_on = 1'b0;
  int   n;

  // Acknowledge shows at the level its polarity names
  assign dma_ack_line = ack_on ~^ ack_pol;

  // Answer a request, release it, then wait for the request to drop
  always begin
    @(posedge ref_clk);
    if (!reset && dma_request_line == req_pol) begin
      repeat (lat) @(posedge ref_clk);
      ack_on <= 1'b1;
      // Hold at least one cycle so ack_on never changes twice in one step
      n = 0;
      do begin
        @(posedge ref_clk);
        n++;
      end while (n < hold && dma_request_line == req_pol);
      ack_on <= 1'b0;
      while (dma_request_line == req_pol)
        @(posedge ref_clk);
    end
  end
endmodule

// ===== testbench/testbench.sv
// Self-checking bench for the host port request and irq block
`timescale 1ns/10ps

module testbench;
  localparam logic [31:0] CFG  = hpdc_pkg::ADDR_HOST_PORT_CONFIG;
  localparam logic [31:0] COPY = hpdc_pkg::ADDR_INTERNAL_IFACE_CONFIG;
  logic        ref_clk   = 1'b0;
  logic        reset     = 1'b1;
  logic        hsel      = 1'b0;
  logic [31:0] haddr     = 32'h0;
  logic [1:0]  htrans    = 2'b00;
  logic        hwrite    = 1'b0;
  logic [31:0] hwdata    = 32'h0;
  logic        dma_ready = 1'b0;
  logic        event_irq = 1'b0;
  logic        word_xfer = 1'b0;
  logic        xfer_last = 1'b0;
  logic        req_pol   = 1'b0;
  logic        ack_pol   = 1'b0;
  logic [7:0]  hold      = 8'h05;
  logic [3:0]  codes [3] = '{4'h0, 4'h2, 4'hf};
  logic        hreadyout;
  logic        hresp;
  logic        ack;
  logic        req;
  logic        irq;
  logic        e;
  logic [31:0] hrdata;
  logic [31:0] rd;
  int          n_fail    = 0;
  int          checks    = 0;
  int          i;
  int          j;
  int          k;
  int          nw;
  int          cnt;

  always #5 ref_clk = ~ref_clk;

  hpdc_top DUT (
    .ref_clk(ref_clk), .reset(reset), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .dma_ready(dma_ready), .event_irq(event_irq),
    .word_xfer(word_xfer), .xfer_last(xfer_last),
    .dma_ack_line(ack), .dma_request_line(req), .host_irq_line(irq));

  hpdc_host_model u_host (
    .ref_clk(ref_clk), .reset(reset), .dma_request_line(req),
    .req_pol(req_pol), .ack_pol(ack_pol), .lat(8'h02), .hold(hold),
    .dma_ack_line(ack));

  // Compare and count
  task automatic chk(input string nm, input logic [31:0] exp, got);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // One AHB-Lite single transfer; read data lands in rd
  task automatic bus(input logic w, input logic [31:0] a, d);
    hsel   <= 1'b1;
    htrans <= hpdc_pkg::HTRANS_NONSEQ;
    haddr  <= a;
    hwrite <= w;
    do @(posedge ref_clk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge ref_clk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask

  task automatic rchk(input string nm, input logic [31:0] a, exp);
    bus(1'b0, a, 32'h0);
    chk(nm, exp, rd);
    chk("response", 32'h0, {31'h0, hresp});
  endtask

  // Bounded wait for the request to reach a logical state
  task automatic wreq(input logic act);
    cnt = 0;
    while ((req === req_pol) !== act && cnt < 300) begin
      @(posedge ref_clk);
      cnt++;
    end
    chk("request state", {31'h0, act}, {31'h0, req === req_pol});
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // Cut a hang short
  initial begin
    #200000;
    n_fail++;
    $display("ERROR watchdog expected finish seen hang");
    summarize();
  end

  // Main sequence
  initial begin
    repeat (3) @(posedge ref_clk);
    reset <= 1'b0;
    rchk("config reset", CFG, {16'h0, hpdc_pkg::CONFIG_RESET});
    rchk("copy reset", COPY, 32'h1);
    rchk("unmapped", 32'h0e0017fc, 32'h0);
    chk("request idle", 32'h1, {31'h0, req});
    chk("irq idle", 32'h1, {31'h0, irq});
    $display("test reset done");
    bus(1'b1, COPY, 32'h0);
    rchk("init cleared", CFG, 32'h5);
    bus(1'b1, CFG, 32'hffffffbf);
    rchk("writable", CFG, {16'h0, hpdc_pkg::CONFIG_WMASK & 16'hffbf});
    bus(1'b1, COPY, 32'h1);
    rchk("init set", CFG, {16'h0, hpdc_pkg::CONFIG_WMASK | 16'h0040});
    $display("test mirror done");
    for (i = 0; i < 16; i++) begin
      bus(1'b1, CFG, {20'h0, i[2:0], 9'h0});
      event_irq <= i[3];
      repeat (3) @(posedge ref_clk);
      e = ~(i[2] ^ (i[0] ? i[1] : i[3]));
      chk("irq pin", {31'h0, e}, {31'h0, irq});
    end
    $display("test irq done");
    for (i = 0; i < 8; i++) begin
      bus(1'b1, CFG, {16'h0, 1'b0, i[1], i[0], !i[2], 12'h0});
      repeat (3) @(posedge ref_clk);
      e = i[2] ? ~i[1] : ~(i[1] ^ i[0]);
      chk("request pin", {31'h0, e}, {31'h0, req});
    end
    $display("test force done");
    for (k = 0; k < 2; k++) begin
      ack_pol <= k[0];
      req_pol <= 1'b1;
      bus(1'b1, CFG, {16'h0, k[0], 1'b1, 14'h0});
      dma_ready <= 1'b1;
      wreq(1'b1);
      wreq(1'b0);
      wreq(1'b1);
      chk("pulse gap", 32'h1,
          {31'h0, cnt >= hpdc_pkg::PULSE_GAP_CYCLES});
      dma_ready <= 1'b0;
      wreq(1'b0);
    end
    $display("test pulse done");
    hold <= 8'hff;
    for (j = 0; j < 3; j++) begin
      bus(1'b1, CFG, {16'h0, 8'hc0, 4'h8, codes[j]});
      dma_ready <= 1'b1;
      wreq(1'b1);
      for (cnt = 0; ack !== ack_pol && cnt < 50; cnt++)
        @(posedge ref_clk);
      repeat (5) @(posedge ref_clk);
      nw = codes[j] == 4'hf ? 4 : 1 << codes[j];
      for (k = 1; k <= nw; k++) begin
        chk("burst on", 32'h1, {31'h0, req === req_pol});
        word_xfer <= 1'b1;
        xfer_last <= codes[j] == 4'hf && k == nw;
        @(posedge ref_clk);
        word_xfer <= 1'b0;
        xfer_last <= 1'b0;
        repeat (3) @(posedge ref_clk);
      end
      chk("burst off", 32'h1, {31'h0, req !== req_pol});
      wreq(1'b1);
    end
    // Status: irq active, request active, ack not yet seen, state request
    rchk("status", hpdc_pkg::ADDR_STATUS,
         {27'h0, 1'b1, 1'b1, 1'b0, hpdc_pkg::HPDC_REQ});
    $display("test burst done");
    summarize();
  end
endmodule
